// ### rtl/sds_pkg.sv
// constants and carrier types for the stacked die select block
// Contract
// - exactly one die is active; only it answers commands and drives the bus.
// - every die takes select opcode plus 8-bit identifier; match becomes active, others idle.
// - every die takes the two-opcode reset pair; all dies return to power-up state.
// - each die holds a fixed identifier and compares select commands against it.
// - an idle die keeps its data outputs undriven on the shared lines.
// - programming works in pages of 256 bytes, the longest single program span.
// - the array divides into uniform 4 kilobyte sectors for erase addressing.
// - sectors group into uniform 32 or 64 kilobyte blocks for block erase.
// - commands carry three or four address bytes per the addressing mode in force.
// - after power-on die zero is the active die and owns the bus.
// - an idle die ignores everything except die select and software reset.
// - die select changes only activity; running program or erase is not interrupted.
package sds_pkg;

   // ************************************************************
   // opcodes and identifiers
   // ************************************************************
   localparam logic [7:0] OP_DIE_SELECT = 8'hC2;
   localparam logic [7:0] OP_RESET_ARM  = 8'h66;
   localparam logic [7:0] OP_RESET_FIRE = 8'h99;
   localparam logic [7:0] DIE_IDENTIFIER_FIRST  = 8'h00;

   // ************************************************************
   // frame lengths in bytes including the opcode; address lengths without it
   // ************************************************************
   localparam logic [2:0] LEN_SELECT = 3'h2;
   localparam logic [2:0] LEN_SINGLE = 3'h1;
   localparam logic [2:0] ADDR3      = 3'h3;
   localparam logic [2:0] ADDR4      = 3'h4;
   localparam logic [2:0] IDX_SAT    = 3'h7;

   // ************************************************************
   // array geometry, as byte sizes and address bit positions
   // ************************************************************
   localparam int PAGE_BYTES    = 256;
   localparam int SECTOR_BYTES  = 4096;
   localparam int PAGE_SHIFT    = 8;
   localparam int SECTOR_SHIFT  = 12;
   localparam int BLOCK32_SHIFT = 15;
   localparam int BLOCK64_SHIFT = 16;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } sds_byte_t;

   typedef struct packed {
      logic [3:0] en;
      logic [3:0] data;
   } sds_tx_t;

   typedef struct packed {
      logic        four_byte;
      logic [31:0] addr;
      logic [23:0] page;
      logic [19:0] sector;
      logic [16:0] block32;
      logic [15:0] block64;
   } sds_addr_t;

endpackage

// ### rtl/sds_die_select.sv
// die activity, shared bus ownership and command front end of one stacked die
`timescale 1ns/100ps
`default_nettype none

module sds_die_select
#(
   parameter logic [7:0] DIE_IDENTIFIER = 8'h00
)
(
   // system clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   // shared serial bus
   input  wire logic                 link_sclk,
   input  wire logic                 link_cs_n,
   input  wire logic [3:0]           io_in,
   output logic      [3:0]           io_out,
   output logic      [3:0]           io_oe,
   // received bytes towards the die core
   output logic                      rx_valid,
   output sds_pkg::sds_byte_t        rx_data,
   input  wire logic                 rx_ready,
   // address mode, decoded address, transmit data
   input  wire logic                 addr4_mode,
   input  wire sds_pkg::sds_tx_t     core_tx,
   output logic                      addr_valid,
   output sds_pkg::sds_addr_t        addr_info,
   // status
   output logic                      die_active,
   output logic                      core_reset,
   output logic                      rx_overrun
);

   // power-up owner of the bus is die zero
   localparam logic ACTIVE_AT_POWERUP = (DIE_IDENTIFIER == sds_pkg::DIE_IDENTIFIER_FIRST);

   // ************************************************************
   // link domain: byte assembly on the serial clock
   // ************************************************************
   logic       link_rst_n;
   logic [2:0] bit_cnt;
   logic [6:0] shift;
   logic [7:0] hold_l;
   logic       tog_l;

   // chip select high ends the frame without needing a clock edge
   assign link_rst_n = resetn & ~link_cs_n;

   // bit counter and shifter, cleared by every deselect
   always_ff @(posedge link_sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         bit_cnt <= 3'h0;
         shift   <= 7'h00;
      end
      else
      begin
         bit_cnt <= bit_cnt + 3'h1;
         shift   <= {shift[5:0], io_in[0]};
      end
   end

   // completed byte held steady while its toggle crosses over
   always_ff @(posedge link_sclk or negedge resetn)
   begin
      if (!resetn)
      begin
         hold_l <= 8'h00;
         tog_l  <= 1'b0;
      end
      else if (!link_cs_n && bit_cnt == 3'h7)
      begin
         hold_l <= {shift, io_in[0]};
         tog_l  <= ~tog_l;
      end
   end

   // ************************************************************
   // link domain: output drivers
   // ************************************************************
   logic             act_l1;
   logic             act_l2;
   sds_pkg::sds_tx_t tx_l1;
   sds_pkg::sds_tx_t tx_l2;

   // activity restarts idle at every deselect: sclk stops between frames,
   // so a level kept from the last frame could let a newly idle die drive
   always_ff @(posedge link_sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         act_l1 <= 1'b0;
         act_l2 <= 1'b0;
      end
      else
      begin
         act_l1 <= die_active;
         act_l2 <= act_l1;
      end
   end

   // transmit levels brought onto the serial clock
   always_ff @(posedge link_sclk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_l1 <= '0;
         tx_l2 <= '0;
      end
      else
      begin
         tx_l1 <= core_tx;
         tx_l2 <= tx_l1;
      end
   end

   // drive on falling edge; an idle die never enables a pin
   always_ff @(negedge link_sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         io_oe  <= 4'h0;
         io_out <= 4'h0;
      end
      else
      begin
         io_oe  <= act_l2 ? tx_l2.en : 4'h0;
         io_out <= tx_l2.data;
      end
   end

   // ************************************************************
   // system domain: crossings
   // ************************************************************
   logic cs_s1;
   logic cs_s2;
   logic cs_s3;
   logic tg_s1;
   logic tg_s2;
   logic tg_s3;
   logic frame_done;
   logic byte_evt;

   // chip select and byte toggle through three flops each
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cs_s1      <= 1'b1;
         cs_s2      <= 1'b1;
         cs_s3      <= 1'b1;
         tg_s1      <= 1'b0;
         tg_s2      <= 1'b0;
         tg_s3      <= 1'b0;
         frame_done <= 1'b0;
      end
      else
      begin
         cs_s1      <= link_cs_n;
         cs_s2      <= cs_s1;
         cs_s3      <= cs_s2;
         tg_s1      <= tog_l;
         tg_s2      <= tg_s1;
         tg_s3      <= tg_s2;
         // one cycle late so a last byte is always decoded first
         frame_done <= cs_s2 & ~cs_s3;
      end
   end

   assign byte_evt = tg_s2 ^ tg_s3;

   // ************************************************************
   // system domain: frame decoding
   // ************************************************************
   logic [2:0] idx;
   logic [7:0] opcode;
   logic [7:0] cand;
   logic       fwd_frame;
   logic       fwd_cur;
   logic       sel_ok;
   logic       rst_ok;
   logic       rst_armed;
   logic [2:0] addr_len;

   assign fwd_cur  = (idx == 3'h0) ? die_active : fwd_frame;
   assign sel_ok   = (opcode == sds_pkg::OP_DIE_SELECT) && (idx == sds_pkg::LEN_SELECT);
   assign rst_ok   = (opcode == sds_pkg::OP_RESET_FIRE) && (idx == sds_pkg::LEN_SINGLE);
   assign addr_len = addr4_mode ? sds_pkg::ADDR4 : sds_pkg::ADDR3;

   // byte position, opcode and identifier; every die listens here
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         idx       <= 3'h0;
         opcode    <= 8'h00;
         cand      <= 8'h00;
         fwd_frame <= 1'b0;
      end
      else if (frame_done)
      begin
         idx <= 3'h0;
      end
      else if (byte_evt)
      begin
         if (idx != sds_pkg::IDX_SAT)
         begin
            idx <= idx + 3'h1;
         end
         if (idx == 3'h0)
         begin
            opcode    <= hold_l;
            fwd_frame <= die_active;
         end
         if (idx == sds_pkg::LEN_SINGLE)
         begin
            cand <= hold_l;
         end
      end
   end

   // ************************************************************
   // system domain: activity and reset pair
   // ************************************************************
   // only complete frames act; a cut-short select changes nothing
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         die_active <= ACTIVE_AT_POWERUP;
         rst_armed  <= 1'b0;
         core_reset <= 1'b0;
      end
      else
      begin
         core_reset <= 1'b0;
         if (frame_done)
         begin
            rst_armed <= 1'b0;
            if (sel_ok)
            begin
               // fixed identifier compare; core work keeps running
               die_active <= (cand == DIE_IDENTIFIER);
            end
            else if (opcode == sds_pkg::OP_RESET_ARM && idx == sds_pkg::LEN_SINGLE)
            begin
               rst_armed <= 1'b1;
            end
            else if (rst_ok && rst_armed)
            begin
               die_active <= ACTIVE_AT_POWERUP;
               core_reset <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // system domain: address capture
   // ************************************************************
   logic [31:0] acc;
   logic [31:0] next_acc;

   assign next_acc = {acc[23:0], hold_l};

   // bytes after the opcode of an owned frame form the address
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         acc        <= 32'h0000_0000;
         addr_valid <= 1'b0;
         addr_info  <= '0;
      end
      else
      begin
         addr_valid <= 1'b0;
         if (byte_evt && fwd_frame && idx != 3'h0 && idx <= addr_len)
         begin
            acc <= next_acc;
            if (idx == addr_len)
            begin
               addr_valid          <= 1'b1;
               addr_info.four_byte <= addr4_mode;
               addr_info.addr      <= next_acc;
               addr_info.page      <= next_acc[31:sds_pkg::PAGE_SHIFT];
               addr_info.sector    <= next_acc[31:sds_pkg::SECTOR_SHIFT];
               addr_info.block32   <= next_acc[31:sds_pkg::BLOCK32_SHIFT];
               addr_info.block64   <= next_acc[31:sds_pkg::BLOCK64_SHIFT];
            end
         end
         else if (byte_evt && idx == 3'h0)
         begin
            acc <= 32'h0000_0000;
         end
      end
   end

   // ************************************************************
   // system domain: pending byte and two-entry buffer
   // ************************************************************
   sds_pkg::sds_byte_t pend_data;
   sds_pkg::sds_byte_t slot1;
   logic               pend;
   logic               v1;
   logic               in_ready;
   logic               push;
   logic               pop;
   logic               take;

   // the serial side cannot stall, so one byte waits here at most
   assign take     = byte_evt & fwd_cur;
   assign in_ready = ~v1;
   assign push     = pend & in_ready;
   assign pop      = rx_valid & rx_ready;

   // pending stage, refilled as it drains; a fourth byte during a stall overruns
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pend       <= 1'b0;
         pend_data  <= '0;
         rx_overrun <= 1'b0;
      end
      else
      begin
         if (take)
         begin
            pend           <= 1'b1;
            pend_data.data <= hold_l;
            pend_data.first <= (idx == 3'h0);
         end
         else if (push)
         begin
            pend <= 1'b0;
         end
         if (take && pend && !push)
         begin
            rx_overrun <= 1'b1;
         end
      end
   end

   // head slot is the output, second slot absorbs a stall
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_valid <= 1'b0;
         rx_data  <= '0;
         v1       <= 1'b0;
         slot1    <= '0;
      end
      else if (pop)
      begin
         if (v1)
         begin
            rx_data <= slot1;
            v1      <= push;
            slot1   <= pend_data;
         end
         else
         begin
            rx_valid <= push;
            rx_data  <= pend_data;
         end
      end
      else if (push)
      begin
         if (!rx_valid)
         begin
            rx_valid <= 1'b1;
            rx_data  <= pend_data;
         end
         else
         begin
            v1    <= 1'b1;
            slot1 <= pend_data;
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_sel_hit;
      frame_done && sel_ok && (cand == DIE_IDENTIFIER);
   endsequence

   sequence s_sel_miss;
      frame_done && sel_ok && (cand != DIE_IDENTIFIER);
   endsequence

   sequence s_reset_pair;
      frame_done && rst_ok && rst_armed;
   endsequence

   AST_SELECT_HIT: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_sel_hit |=> die_active)
      else $error("matching select left die idle");

   AST_SELECT_MISS: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_sel_miss |=> !die_active)
      else $error("foreign select left die active");

   AST_ACTIVE_ONLY_AT_END: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(die_active) |-> $past(frame_done) && ($past(sel_ok) || $past(rst_ok)))
      else $error("activity changed outside a complete frame");

   AST_RESET_PAIR: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_reset_pair |=> (core_reset && die_active == ACTIVE_AT_POWERUP) ##1 !core_reset)
      else $error("reset pair did not restore power-up state");

   AST_SELECT_KEEPS_CORE: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_done && sel_ok |=> !core_reset)
      else $error("select disturbed the die core");

   AST_IDLE_SILENT: assert property (@(posedge clk_sys) disable iff (!resetn)
      byte_evt && idx == 3'h0 && !die_active |=> !fwd_frame && !$rose(pend))
      else $error("idle die forwarded a byte");

   AST_BUS_RELEASED: assert property (@(negedge link_sclk) disable iff (!resetn)
      !act_l2 |=> io_oe == 4'h0)
      else $error("idle die drove the shared bus");

   AST_IDLE_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!resetn)
      io_oe != 4'h0 |-> die_active)
      else $error("pin enabled while die idle");

   AST_ADDR_WIDTH: assert property (@(posedge clk_sys) disable iff (!resetn)
      addr_valid |-> idx == (addr_info.four_byte ? sds_pkg::ADDR4 + 3'h1 : sds_pkg::ADDR3 + 3'h1))
      else $error("address closed at wrong byte count");

   AST_GEOMETRY: assert property (@(posedge clk_sys) disable iff (!resetn)
      addr_valid |-> addr_info.page == addr_info.addr[31:8] && addr_info.sector[3:0] == addr_info.addr[15:12])
      else $error("page or sector index mismatch");

   AST_STALL_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("stalled byte was lost");

endmodule

`default_nettype wire

// ### testbench/sds_ctrl_model.sv
// serial flash controller model driving the shared bus of the stacked dies
`timescale 1ns/100ps
`default_nettype none

module sds_ctrl_model
(
   // shared serial bus, controller side
   output logic       link_sclk,
   output logic       link_cs_n,
   output logic [3:0] ctl_io
);
   // idle bus: select held high from time zero, clock parked low
   initial
   begin
      link_sclk = 1'b0;
      link_cs_n = 1'b1;
      ctl_io    = 4'h0;
   end

   // one bit set up while the clock is low, taken by the die on the rise
   task automatic put_bit(input logic b);
   begin
      ctl_io = {~ctl_io[3:1], b};
      #6 link_sclk = 1'b1;
      #6 link_sclk = 1'b0;
   end
   endtask

   // whole bytes msb first, then stray bits to cut a frame short
   task automatic frame(input logic [7:0] q[$], input int tail);
   begin
      link_cs_n = 1'b0;
      #5;
      for (int i = 0; i < q.size(); i++)
         for (int k = 7; k >= 0; k--)
            put_bit(q[i][k]);
      for (int k = 0; k < tail; k++)
         put_bit(1'b1);
      #6 link_cs_n = 1'b1;
      ctl_io = ~ctl_io; // a released line must not keep its last level
      #90;
   end
   endtask
endmodule
`default_nettype wire

// ### testbench/stacked_die_select_tb_top.sv
// self-checking bench for the stacked die select front end
`timescale 1ns/100ps
`default_nettype none

module stacked_die_select_tb_top;
   // ************************************************************
   // signals
   // ************************************************************
   logic               clk_sys;
   logic               resetn;
   logic               link_sclk;
   logic               link_cs_n;
   logic [3:0]         ctl_io;
   logic [3:0]         io_bus;
   logic [3:0]         io_out;
   logic [3:0]         io_oe;
   logic               rx_valid;
   sds_pkg::sds_byte_t rx_data;
   logic               rx_ready;
   logic               addr4_mode;
   sds_pkg::sds_tx_t   core_tx;
   logic               addr_valid;
   sds_pkg::sds_addr_t addr_info;
   sds_pkg::sds_addr_t addr_seen;
   logic               die_active;
   logic               core_reset;
   logic               rx_overrun;
   logic [3:0]         oe_seen;
   logic [3:0]         out_seen;
   int                 n_mismatch;
   int                 comparisons;
   int                 n_addr;
   int                 n_reset;
   int                 cycles;
   sds_pkg::sds_byte_t rxq[$];

   // wire level: the die wins where it drives, the controller elsewhere
   assign io_bus = (io_oe & io_out) | (~io_oe & ctl_io);

   // system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   sds_die_select #(.DIE_IDENTIFIER(8'h00)) DUT
   (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .link_sclk  (link_sclk),
      .link_cs_n  (link_cs_n),
      .io_in      (io_bus),
      .io_out     (io_out),
      .io_oe      (io_oe),
      .rx_valid   (rx_valid),
      .rx_data    (rx_data),
      .rx_ready   (rx_ready),
      .addr4_mode (addr4_mode),
      .core_tx    (core_tx),
      .addr_valid (addr_valid),
      .addr_info  (addr_info),
      .die_active (die_active),
      .core_reset (core_reset),
      .rx_overrun (rx_overrun)
   );

   sds_ctrl_model ctrl
   (
      .link_sclk (link_sclk),
      .link_cs_n (link_cs_n),
      .ctl_io    (ctl_io)
   );

   // ************************************************************
   // observers and hang guard
   // ************************************************************
   // records pops, address pulses, reset pulses and any pin drive
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
         rxq.push_back(rx_data);
      if (addr_valid === 1'b1)
      begin
         addr_seen <= addr_info;
         n_addr    <= n_addr + 1;
      end
      if (core_reset === 1'b1)
         n_reset <= n_reset + 1;
      oe_seen  <= oe_seen | io_oe;
      out_seen <= out_seen | (io_out & io_oe);
      if (cycles == 5000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
   begin
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask

   task automatic print_verdict();
   begin
      $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   // waits, then drives just after the edge
   task automatic tick(input int n);
   begin
      repeat (n) @(posedge clk_sys);
      #1;
   end
   endtask

   task automatic clear_obs();
   begin
      tick(1);
      rxq.delete();
      oe_seen  = 4'h0;
      out_seen = 4'h0;
      n_addr   = 0;
      n_reset  = 0;
   end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_power_up();
   begin
      check(die_active, 1'b1);
      check(io_oe, 4'h0);
      check(rx_valid, 1'b0);
   end
   endtask

   // active die forwards the select and hands the bus away
   task automatic t_select_away();
   begin
      clear_obs();
      ctrl.frame('{8'hC2, 8'h01}, 0);
      check(die_active, 1'b0);
      check(rxq.size(), 2);
      check(rxq[0], {1'b1, 8'hC2});
      check(rxq[1], {1'b0, 8'h01});
   end
   endtask

   // idle die: plain command, overlong select, short select
   task automatic t_idle_ignores();
   begin
      clear_obs();
      ctrl.frame('{8'h03, 8'h00, 8'h10, 8'h00}, 0);
      ctrl.frame('{8'hC2, 8'h00, 8'h00}, 0);
      ctrl.frame('{8'hC2}, 5);
      check(die_active, 1'b0);
      check(rxq.size(), 0);
      check(n_addr, 0);
      check(oe_seen, 4'h0);
   end
   endtask

   // broken reset pair does nothing, a clean pair revives die zero
   task automatic t_reset_pair();
   begin
      clear_obs();
      ctrl.frame('{8'h66}, 0);
      ctrl.frame('{8'h05}, 0);
      ctrl.frame('{8'h99}, 0);
      check(die_active, 1'b0);
      check(n_reset, 0);
      ctrl.frame('{8'h66}, 0);
      ctrl.frame('{8'h99}, 0);
      check(die_active, 1'b1);
      check(n_reset, 1);
   end
   endtask

   // back-to-back selects away and home again
   task automatic t_select_back();
   begin
      ctrl.frame('{8'hC2, 8'h01}, 0);
      check(die_active, 1'b0);
      ctrl.frame('{8'hC2, 8'h00}, 0);
      check(die_active, 1'b1);
   end
   endtask

   task automatic chk_addr(input logic [31:0] a, input logic fb);
   begin
      check(n_addr, 1);
      check(addr_seen.four_byte, fb);
      check(addr_seen.addr, a);
      check(addr_seen.page, a >> sds_pkg::PAGE_SHIFT);
      check(addr_seen.sector, a >> sds_pkg::SECTOR_SHIFT);
      check(addr_seen.block32, a >> sds_pkg::BLOCK32_SHIFT);
      check(addr_seen.block64, a >> sds_pkg::BLOCK64_SHIFT);
   end
   endtask

   // both address widths; the active die drives only its enabled pin
   task automatic t_address();
   begin
      clear_obs();
      addr4_mode = 1'b0;
      ctrl.frame('{8'h03, 8'h12, 8'h34, 8'h56}, 0);
      chk_addr(32'h00123456, 1'b0);
      check(oe_seen, 4'h2);
      check(out_seen, 4'h2);
      clear_obs();
      addr4_mode = 1'b1;
      ctrl.frame('{8'h13, 8'h01, 8'h23, 8'h45, 8'h67}, 0);
      chk_addr(32'h01234567, 1'b1);
   end
   endtask

   // stalled core: three bytes held, then a burst that overflows
   task automatic t_buffer();
   begin
      clear_obs();
      rx_ready = 1'b0;
      ctrl.frame('{8'h05, 8'h11, 8'h22}, 0);
      tick(1);
      check(rx_valid, 1'b1);
      check(rx_data, {1'b1, 8'h05});
      check(rx_overrun, 1'b0);
      rx_ready = 1'b1;
      tick(8);
      check(rxq.size(), 3);
      check(rxq[2], {1'b0, 8'h22});
      rx_ready = 1'b0;
      ctrl.frame('{8'h05, 8'h01, 8'h02, 8'h03, 8'h04}, 0);
      tick(1);
      check(rx_overrun, 1'b1);
      rx_ready = 1'b1;
      tick(8);
      check(rx_valid, 1'b0);
   end
   endtask

   // reset in mid-run: an idle die zero owns the bus again, sticky flag clears
   task automatic t_mid_reset();
   begin
      ctrl.frame('{8'hC2, 8'h01}, 0);
      tick(1);
      check(die_active, 1'b0);
      resetn = 1'b0;
      tick(2);
      check(die_active, 1'b1);
      tick(3);
      resetn = 1'b1;
      tick(4);
      check(die_active, 1'b1);
      check(rx_overrun, 1'b0);
      check(rx_valid, 1'b0);
      check(io_oe, 4'h0);
   end
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      resetn      = 1'b0;
      rx_ready    = 1'b1;
      addr4_mode  = 1'b0;
      core_tx     = 8'h22;
      oe_seen     = 4'h0;
      out_seen    = 4'h0;
      n_mismatch  = 0;
      comparisons = 0;
      n_addr      = 0;
      n_reset     = 0;
      cycles      = 0;
      repeat (5) @(posedge clk_sys);
      #1 resetn = 1'b1;
      tick(4);
      t_power_up();
      t_select_away();
      t_idle_ignores();
      t_reset_pair();
      t_select_back();
      t_address();
      t_buffer();
      t_mid_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
